// *** src/fine_edge_timing.sv ***
/*
 * Fine-edge timing generator: reset-gate pulse, two horizontal clocks with
 * their inverses, two sample clocks and the output data phase, all placed
 * on 48 positions of the pixel period, configured over the serial port.
 * Assumes core_clk runs at 48 times the pixel rate and all inputs are
 * synchronous to it.
 */
// Functional notes
// - Each pixel period is split into 48 positions; every edge lands on one.
// - Reset-gate pulse has programmable rise and fall and optional inversion.
// - Horizontal clocks A and B have programmable edges and own polarity.
// - Inverse outputs are always the logical inverse of A and B.
// - Edge fields are 6 bits holding 48 positions in four quadrants of 12.
// - Field 0-11, 16-27, 32-43, 48-59 decode to positions 0-47.
// - Each driver has a 3-bit current code; code 0 three-states it.
// - Reference and data sample clocks each sit at one position 0-47.
// - Polarity bit 0 keeps the waveform, 1 inverts it.
// - Output data changes at a programmable position 0-47.
// - Each edge channel has its own 6-bit rising and falling field.
// - Horizontal A falling field resets to 20 hex, rising to zero.
// - Reset-gate falling field resets to 10 hex, rising to zero.
`timescale 1ns/100ps
module fine_edge_timing
	import fine_timing_pkg::*;
(
	// Clock and reset.
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// Serial configuration port.
	input  wire logic              ser_clk,
	input  wire logic              ser_data,
	input  wire logic              ser_load_n,
	// Converter data in and phased data out.
	input  wire logic [DATA_W-1:0] adc_data,
	output logic      [DATA_W-1:0] data_out,
	output logic                   data_strobe,
	// Sensor clocks.
	output logic                   horiz_clock_a,
	output logic                   horiz_clock_a_inverse,
	output logic                   horiz_clock_b,
	output logic                   horiz_clock_b_inverse,
	output logic                   reset_gate_pulse,
	output logic                   reference_sample_clock,
	output logic                   data_sample_clock,
	output logic                   pixel_start,
	// Driver current codes and enables (enable low while driving).
	output logic [DRV_W-1:0]       drive_ha,
	output logic [DRV_W-1:0]       drive_ha_inv,
	output logic [DRV_W-1:0]       drive_hb,
	output logic [DRV_W-1:0]       drive_hb_inv,
	output logic [DRV_W-1:0]       drive_rg,
	output logic [4:0]             drive_off
);

	reg_write_t        wr;
	edge_cfg_t         cfg [NUM_CH];
	logic [5:0]        ref_pos;
	logic [5:0]        dat_pos;
	logic [5:0]        output_phase_select;
	logic [5:0]        pos;
	logic [NUM_CH-1:0] wave;
	logic [NUM_CH-1:0] next_wave;
	logic [NUM_CH-1:0] shaped;

	serial_reg_port u_port (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.ser_clk    (ser_clk),
		.ser_data   (ser_data),
		.ser_load_n (ser_load_n),
		.wr         (wr)
	);

	// Quadrant code to position: upper two bits times 12 plus the low nibble.
	function automatic logic [5:0] decode_edge(input logic [5:0] code);
		logic [5:0] base;
		base = 6'(code[5:4] * QUAD_SPAN);
		return base + {2'b00, code[3:0]};
	endfunction

	// Register write decode.
	wire sel_ha_pol  = wr.strobe && wr.addr == ADDR_HA_POL;
	wire sel_ha_rise = wr.strobe && wr.addr == ADDR_HA_RISE;
	wire sel_ha_fall = wr.strobe && wr.addr == ADDR_HA_FALL;
	wire sel_hb_pol  = wr.strobe && wr.addr == ADDR_HB_POL;
	wire sel_hb_rise = wr.strobe && wr.addr == ADDR_HB_RISE;
	wire sel_hb_fall = wr.strobe && wr.addr == ADDR_HB_FALL;
	wire sel_rg_pol  = wr.strobe && wr.addr == ADDR_RG_POL;
	wire sel_rg_rise = wr.strobe && wr.addr == ADDR_RG_RISE;
	wire sel_rg_fall = wr.strobe && wr.addr == ADDR_RG_FALL;
	wire sel_ha_drv  = wr.strobe && wr.addr == ADDR_HA_DRV;
	wire sel_hai_drv = wr.strobe && wr.addr == ADDR_HAI_DRV;
	wire sel_hb_drv  = wr.strobe && wr.addr == ADDR_HB_DRV;
	wire sel_hbi_drv = wr.strobe && wr.addr == ADDR_HBI_DRV;
	wire sel_rg_drv  = wr.strobe && wr.addr == ADDR_RG_DRV;
	wire sel_ref     = wr.strobe && wr.addr == ADDR_REF_POS;
	wire sel_dat     = wr.strobe && wr.addr == ADDR_DAT_POS;
	wire sel_ph      = wr.strobe && wr.addr == ADDR_OUT_PH;

	// Next drive codes, so the three-state flags change in the same cycle as the codes.
	wire [DRV_W-1:0] next_drive_ha     = sel_ha_drv  ? wr.data[2:0] : drive_ha;
	wire [DRV_W-1:0] next_drive_ha_inv = sel_hai_drv ? wr.data[2:0] : drive_ha_inv;
	wire [DRV_W-1:0] next_drive_hb     = sel_hb_drv  ? wr.data[2:0] : drive_hb;
	wire [DRV_W-1:0] next_drive_hb_inv = sel_hbi_drv ? wr.data[2:0] : drive_hb_inv;
	wire [DRV_W-1:0] next_drive_rg     = sel_rg_drv  ? wr.data[2:0] : drive_rg;

	// Edge channel configuration registers.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg[CH_HA] <= '{pol: RST_POL, rise: RST_HA_RISE, fall: RST_HA_FALL};
			cfg[CH_HB] <= '{pol: RST_POL, rise: RST_HB_RISE, fall: RST_HB_FALL};
			cfg[CH_RG] <= '{pol: RST_POL, rise: RST_RG_RISE, fall: RST_RG_FALL};
		end else begin
			if (sel_ha_pol)  cfg[CH_HA].pol  <= wr.data[0];
			if (sel_ha_rise) cfg[CH_HA].rise <= wr.data[5:0];
			if (sel_ha_fall) cfg[CH_HA].fall <= wr.data[5:0];
			if (sel_hb_pol)  cfg[CH_HB].pol  <= wr.data[0];
			if (sel_hb_rise) cfg[CH_HB].rise <= wr.data[5:0];
			if (sel_hb_fall) cfg[CH_HB].fall <= wr.data[5:0];
			if (sel_rg_pol)  cfg[CH_RG].pol  <= wr.data[0];
			if (sel_rg_rise) cfg[CH_RG].rise <= wr.data[5:0];
			if (sel_rg_fall) cfg[CH_RG].fall <= wr.data[5:0];
		end
	end

	// Drive codes, sample and output-phase positions.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			drive_ha            <= RST_H_DRV;
			drive_ha_inv        <= RST_H_DRV;
			drive_hb            <= RST_H_DRV;
			drive_hb_inv        <= RST_H_DRV;
			drive_rg            <= RST_RG_DRV;
			ref_pos             <= RST_REF_POS;
			dat_pos             <= RST_DAT_POS;
			output_phase_select <= RST_OUT_PH;
		end else begin
			drive_ha     <= next_drive_ha;
			drive_ha_inv <= next_drive_ha_inv;
			drive_hb     <= next_drive_hb;
			drive_hb_inv <= next_drive_hb_inv;
			drive_rg     <= next_drive_rg;
			if (sel_ref)     ref_pos      <= wr.data[5:0];
			if (sel_dat)     dat_pos      <= wr.data[5:0];
			if (sel_ph)      output_phase_select <= wr.data[5:0];
		end
	end

	// Position counter: one core_clk per position, 48 per pixel period.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pos <= 6'h00;
		end else begin
			pos <= (pos == POS_LAST) ? 6'h00 : pos + 6'h01;
		end
	end

	// Edge channels: set at the rising position, cleared at the falling one.
	for (genvar i = 0; i < NUM_CH; i++) begin : g_edge
		wire hit_rise = pos == decode_edge(cfg[i].rise);
		wire hit_fall = pos == decode_edge(cfg[i].fall);
		assign next_wave[i] = hit_rise ? 1'b1 : (hit_fall ? 1'b0 : wave[i]);
		assign shaped[i]    = next_wave[i] ^ cfg[i].pol;
	end

	// One process holds all channel states so each bit has a single driver.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wave <= '0;
		end else begin
			wave <= next_wave;
		end
	end

	wire ref_hit   = pos == decode_edge(ref_pos);
	wire dat_hit   = pos == decode_edge(dat_pos);
	wire phase_hit = pos == decode_edge(output_phase_select);
	wire [4:0] next_off = {next_drive_rg == 3'h0, next_drive_hb_inv == 3'h0, next_drive_hb == 3'h0,
		next_drive_ha_inv == 3'h0, next_drive_ha == 3'h0};

	// Registered outputs.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			horiz_clock_a          <= 1'b0;
			horiz_clock_a_inverse  <= 1'b1;
			horiz_clock_b          <= 1'b0;
			horiz_clock_b_inverse  <= 1'b1;
			reset_gate_pulse       <= 1'b0;
			reference_sample_clock <= 1'b0;
			data_sample_clock      <= 1'b0;
			pixel_start            <= 1'b0;
			data_out               <= '0;
			data_strobe            <= 1'b0;
			drive_off              <= 5'h00;
		end else begin
			horiz_clock_a          <= shaped[CH_HA];
			horiz_clock_a_inverse  <= ~shaped[CH_HA];
			horiz_clock_b          <= shaped[CH_HB];
			horiz_clock_b_inverse  <= ~shaped[CH_HB];
			reset_gate_pulse       <= shaped[CH_RG];
			reference_sample_clock <= ref_hit;
			data_sample_clock      <= dat_hit;
			pixel_start            <= pos == 6'h00;
			data_strobe            <= phase_hit;
			if (phase_hit) data_out <= adc_data;
			drive_off              <= next_off;
		end
	end

endmodule

// *** src/fine_timing_pkg.sv ***
/*
 * Constants and types for the fine-edge timing generator: register
 * addresses, reset values, field widths and the serial frame format.
 * Assumes nothing of its surroundings; imported whole by the design modules.
 */
package fine_timing_pkg;

	localparam int EDGE_W      = 6;
	localparam int POS_COUNT   = 48;
	localparam int QUAD_SPAN   = 12;
	localparam int DRV_W       = 3;
	localparam int DATA_W      = 12;
	localparam int ADDR_W      = 8;
	localparam int REG_W       = 8;
	localparam int FRAME_BITS  = ADDR_W + REG_W;
	localparam int CLK_MHZ     = 125;
	localparam int NUM_CH      = 3;

	localparam logic [5:0] POS_LAST = 6'h2f;

	// Register addresses on the serial port.
	localparam logic [7:0] ADDR_HA_POL   = 8'he5;
	localparam logic [7:0] ADDR_HA_RISE  = 8'he6;
	localparam logic [7:0] ADDR_HA_FALL  = 8'he7;
	localparam logic [7:0] ADDR_HA_DRV   = 8'he8;
	localparam logic [7:0] ADDR_HAI_DRV  = 8'he9;
	localparam logic [7:0] ADDR_HB_DRV   = 8'hea;
	localparam logic [7:0] ADDR_HBI_DRV  = 8'heb;
	localparam logic [7:0] ADDR_RG_POL   = 8'hec;
	localparam logic [7:0] ADDR_RG_RISE  = 8'hed;
	localparam logic [7:0] ADDR_RG_FALL  = 8'hee;
	localparam logic [7:0] ADDR_RG_DRV   = 8'hef;
	localparam logic [7:0] ADDR_REF_POS  = 8'hf0;
	localparam logic [7:0] ADDR_DAT_POS  = 8'hf1;
	localparam logic [7:0] ADDR_HB_POL   = 8'hf2;
	localparam logic [7:0] ADDR_HB_RISE  = 8'hf3;
	localparam logic [7:0] ADDR_HB_FALL  = 8'hf4;
	localparam logic [7:0] ADDR_OUT_PH   = 8'hf5;

	// Values after reset.
	localparam logic       RST_POL       = 1'b0;
	localparam logic [5:0] RST_HA_RISE   = 6'h00;
	localparam logic [5:0] RST_HA_FALL   = 6'h20;
	localparam logic [5:0] RST_HB_RISE   = 6'h00;
	localparam logic [5:0] RST_HB_FALL   = 6'h20;
	localparam logic [5:0] RST_RG_RISE   = 6'h00;
	localparam logic [5:0] RST_RG_FALL   = 6'h10;
	localparam logic [2:0] RST_H_DRV     = 3'h3;
	localparam logic [2:0] RST_RG_DRV    = 3'h2;
	localparam logic [5:0] RST_REF_POS   = 6'h24;
	localparam logic [5:0] RST_DAT_POS   = 6'h00;
	localparam logic [5:0] RST_OUT_PH    = 6'h00;

	// Channel indices of the programmable edge channels.
	localparam int CH_HA = 0;
	localparam int CH_HB = 1;
	localparam int CH_RG = 2;

	typedef struct packed {
		logic       pol;
		logic [5:0] rise;
		logic [5:0] fall;
	} edge_cfg_t;

	typedef struct packed {
		logic       strobe;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_t;

	typedef enum logic [2:0] {
		SER_IDLE  = 3'b001,
		SER_SHIFT = 3'b010,
		SER_DONE  = 3'b100
	} ser_state_t;

endpackage

// *** src/serial_reg_port.sv ***
/*
 * Three-wire serial write port: a frame is 8 address bits then 8 data bits,
 * least significant bit first, sampled on rising serial clock while the
 * load line is low. Assumes the serial pins are synchronous to core_clk.
 */
`timescale 1ns/100ps
module serial_reg_port
	import fine_timing_pkg::*;
(
	// Clock and reset.
	input  wire logic  core_clk,
	input  wire logic  sys_rst,
	// Serial pins.
	input  wire logic  ser_clk,
	input  wire logic  ser_data,
	input  wire logic  ser_load_n,
	// Decoded write.
	output reg_write_t wr
);

	ser_state_t        state;
	ser_state_t        next_state;
	logic              clk_prev;
	logic [4:0]        bit_cnt;
	logic [15:0]       shift;
	wire               sck_rise = ser_clk & ~clk_prev;
	wire               take_bit = sck_rise & ~ser_load_n;
	wire               last_bit = take_bit && (bit_cnt == 5'(FRAME_BITS - 1));

	always_comb begin
		next_state = state;
		case (state)
			SER_IDLE:  if (!ser_load_n) next_state = SER_SHIFT;
			SER_SHIFT: if (ser_load_n) next_state = SER_IDLE;
				else if (last_bit) next_state = SER_DONE;
			SER_DONE:  if (ser_load_n) next_state = SER_IDLE;
			default:   next_state = SER_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state    <= SER_IDLE;
			clk_prev <= 1'b0;
			bit_cnt  <= 5'h00;
			shift    <= 16'h0000;
			wr       <= '0;
		end else begin
			state    <= next_state;
			clk_prev <= ser_clk;
			wr.strobe <= (state == SER_SHIFT) && last_bit;
			wr.addr   <= shift[8:1];
			wr.data   <= {ser_data, shift[15:9]};
			if (state != SER_SHIFT || ser_load_n) begin
				bit_cnt <= 5'h00;
			end else if (take_bit) begin
				bit_cnt <= bit_cnt + 5'h01;
				shift   <= {ser_data, shift[15:1]};
			end
		end
	end

endmodule

// *** bench/fine_edge_timing_asserts.sv ***
/* Port checker for the fine-edge timing generator.
   Assumes it is bound to fine_edge_timing and sees only its ports. */
`timescale 1ns/100ps
module fine_edge_timing_asserts
	import fine_timing_pkg::*;
(
	// Clock and reset.
	input wire logic              core_clk,
	input wire logic              sys_rst,
	// Watched outputs.
	input wire logic [DATA_W-1:0] data_out,
	input wire logic              data_strobe,
	input wire logic              horiz_clock_a,
	input wire logic              horiz_clock_a_inverse,
	input wire logic              horiz_clock_b,
	input wire logic              horiz_clock_b_inverse,
	input wire logic              reset_gate_pulse,
	input wire logic              reference_sample_clock,
	input wire logic              data_sample_clock,
	input wire logic              pixel_start,
	input wire logic [DRV_W-1:0]  drive_ha,
	input wire logic [DRV_W-1:0]  drive_rg,
	input wire logic [4:0]        drive_off
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [5:0] gap;
	logic       seen;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gap  <= 6'h00;
			seen <= 1'b0;
		end else begin
			gap  <= pixel_start ? 6'h00 : gap + 6'h01;
			seen <= seen | pixel_start;
		end
	end
	AST_PERIOD: assert property (pixel_start && seen |-> gap == 6'h2f)
		else $error("pixel period is not 48 cycles");
	AST_HA_INV: assert property (horiz_clock_a_inverse == !horiz_clock_a)
		else $error("clock a inverse mismatch");
	AST_HB_INV: assert property (horiz_clock_b_inverse == !horiz_clock_b)
		else $error("clock b inverse mismatch");
	AST_OFF_HA: assert property (drive_off[0] == (drive_ha == 3'h0))
		else $error("clock a three-state mismatch");
	AST_OFF_RG: assert property (drive_off[4] == (drive_rg == 3'h0))
		else $error("reset gate three-state mismatch");
	AST_REF_PULSE: assert property (reference_sample_clock |=> !reference_sample_clock [*8])
		else $error("reference sample pulse too long");
	AST_DAT_PULSE: assert property (data_sample_clock |=> !data_sample_clock [*8])
		else $error("data sample pulse too long");
	AST_DATA_PHASE: assert property ($changed(data_out) |-> data_strobe)
		else $error("output data changed off phase");
	AST_RST_DRV: assert property ($fell(sys_rst) |-> drive_ha == RST_H_DRV && drive_rg == RST_RG_DRV)
		else $error("drive codes wrong after reset");
endmodule
bind fine_edge_timing fine_edge_timing_asserts i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
	.data_out(data_out), .data_strobe(data_strobe), .horiz_clock_a(horiz_clock_a),
	.horiz_clock_a_inverse(horiz_clock_a_inverse), .horiz_clock_b(horiz_clock_b),
	.horiz_clock_b_inverse(horiz_clock_b_inverse), .reset_gate_pulse(reset_gate_pulse),
	.reference_sample_clock(reference_sample_clock), .data_sample_clock(data_sample_clock),
	.pixel_start(pixel_start), .drive_ha(drive_ha), .drive_rg(drive_rg), .drive_off(drive_off));

// *** bench/ccd_sensor_model.sv ***
/* Sensor-side model: takes the clocks and returns a converter word.
   Assumes its inputs are the timing generator outputs. */
`timescale 1ns/100ps
module ccd_sensor_model
	import fine_timing_pkg::*;
(
	// Clock.
	input  wire logic              core_clk,
	// Sensor clock inputs.
	input  wire logic              horiz_clock_a,
	input  wire logic              reset_gate_pulse,
	// Converter word.
	output logic      [DATA_W-1:0] adc_data
);
	// The word changes every cycle so a capture at the wrong phase shows.
	logic [DATA_W-1:0] charge = 12'h5a3;
	initial adc_data = 12'h000;
	always @(posedge core_clk) begin
		charge   <= charge + {11'h000, horiz_clock_a} + 12'h00b;
		adc_data <= charge ^ {DATA_W{reset_gate_pulse}};
	end
endmodule

// *** bench/tb_top.sv ***
/* Self-checking bench for the fine-edge timing generator.
   Assumes the package and design files are compiled first. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb_top
	import fine_timing_pkg::*;
;
	localparam int PB[3] = '{0, 13, 7};
	localparam int DI[5] = '{3, 4, 5, 6, 10};
	logic              core_clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              ser_clk = 1'b0;
	logic              ser_data = 1'b0;
	logic              ser_load_n = 1'b1;
	logic [DATA_W-1:0] adc_data;
	logic [DATA_W-1:0] data_out;
	logic              stb, ha, hai, hb, hbi, rg, refc, datc, pix;
	logic [DRV_W-1:0]  dv [5];
	logic [4:0]        doff;
	int                rv[17], m, mask, compares, mismatches, seed = 96291;
	logic              wv[3], er, ed, es;
	logic [DATA_W-1:0] eo;
	always #4 core_clk = ~core_clk;
	fine_edge_timing i_fine_edge_timing (.core_clk(core_clk), .sys_rst(sys_rst), .ser_clk(ser_clk),
		.ser_data(ser_data), .ser_load_n(ser_load_n), .adc_data(adc_data), .data_out(data_out),
		.data_strobe(stb), .horiz_clock_a(ha), .horiz_clock_a_inverse(hai), .horiz_clock_b(hb),
		.horiz_clock_b_inverse(hbi), .reset_gate_pulse(rg), .reference_sample_clock(refc),
		.data_sample_clock(datc), .pixel_start(pix), .drive_ha(dv[0]), .drive_ha_inv(dv[1]),
		.drive_hb(dv[2]), .drive_hb_inv(dv[3]), .drive_rg(dv[4]), .drive_off(doff));
	ccd_sensor_model i_ccd_sensor_model (.core_clk(core_clk), .horiz_clock_a(ha),
		.reset_gate_pulse(rg), .adc_data(adc_data));
	function automatic int dc(input int c);
		return (c >> 4) * 12 + (c & 15);
	endfunction
	always @(posedge core_clk) begin
		if (mask > 0)
			mask--;
		if (sys_rst) begin
			m = 0;
			wv = '{1'b0, 1'b0, 1'b0};
			{er, ed, es, eo} = '0;
		end else begin
			for (int i = 0; i < 3; i++)
				wv[i] = (m == dc(rv[PB[i] + 1])) | (wv[i] & (m != dc(rv[PB[i] + 2])));
			er = m == dc(rv[11]);
			ed = m == dc(rv[12]);
			es = m == dc(rv[16]);
			if (es)
				eo = adc_data;
			m = (m + 1) % 48;
		end
	end
	always @(negedge core_clk) begin
		if (!sys_rst && mask == 0) begin
			`CHK("pixel_start", m == 1, pix)
			`CHK("clock_a", wv[0] ^ rv[0][0], ha)
			`CHK("clock_a_inv", ~(wv[0] ^ rv[0][0]), hai)
			`CHK("clock_b", wv[1] ^ rv[13][0], hb)
			`CHK("clock_b_inv", ~(wv[1] ^ rv[13][0]), hbi)
			`CHK("reset_gate", wv[2] ^ rv[7][0], rg)
			`CHK("ref_sample", er, refc)
			`CHK("data_sample", ed, datc)
			`CHK("strobe", es, stb)
			`CHK("data_out", eo, data_out)
			for (int i = 0; i < 5; i++) begin
				`CHK("drive", rv[DI[i]][2:0], dv[i])
				`CHK("drive_off", rv[DI[i]] == 0, doff[i])
			end
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
		logic [15:0] f;
		f = {d, a};
		mask = 100;
		ser_load_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			ser_data <= f[i];
			repeat (2) @(posedge core_clk);
			ser_clk <= 1'b1;
			repeat (2) @(posedge core_clk);
			ser_clk <= 1'b0;
		end
		repeat (2) @(posedge core_clk);
		ser_load_n <= 1'b1;
		if (n == 16 && a >= ADDR_HA_POL && a <= ADDR_OUT_PH)
			rv[a - ADDR_HA_POL] = d;
		mask = 100;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		logic [31:0] v;
		logic [7:0]  d;
		rv = '{RST_POL, RST_HA_RISE, RST_HA_FALL, RST_H_DRV, RST_H_DRV, RST_H_DRV, RST_H_DRV, RST_POL,
			RST_RG_RISE, RST_RG_FALL, RST_RG_DRV, RST_REF_POS, RST_DAT_POS, RST_POL, RST_HB_RISE,
			RST_HB_FALL, RST_OUT_PH};
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (150) @(posedge core_clk);
		for (int it = 0; it < 8; it++) begin
			for (int k = 0; k < 17; k++) begin
				v = $random(seed);
				d = (k == 0 || k == 7 || k == 13) ? {7'h00, v[0]} : (k inside {3, 4, 5, 6, 10}) ?
					8'((it + k) % 8) : {2'b00, v[5:4], v[3:0] % 4'hc};
				wr(ADDR_HA_POL + 8'(k), d, 16);
			end
			wr(8'h10, v[7:0], 16);
			wr(ADDR_HA_RISE, v[15:8], 8);
			repeat (150) @(posedge core_clk);
		end
		end_sim;
	end
	initial begin
		#500000;
		mismatches++;
		end_sim;
	end
endmodule
